/* rtl/cpb_pkg.sv */
// Purpose: Shared constants, types and address helpers for the CPU program counter
//          and register bank block.
// Assumes: 64K byte address space, 16-bit program counter, 8-bit data.
// Notes:   Data RAM indices are byte addresses minus the RAM base.
package cpb_pkg;

  // Clock and timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TRAP_TIME_NS  = 1000;  // Length of the trap reset pulse
  localparam int          TRAP_CYCLES   = (TRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  TRAP_LAST     = 7'(TRAP_CYCLES - 1);

  // Address map
  localparam logic [15:0] VEC_HI_ADDR   = 16'hFFFF;
  localparam logic [15:0] VEC_LO_ADDR   = 16'hFFFE;
  localparam logic [15:0] PC_AHEAD      = 16'h0002;
  localparam logic [15:0] RAM_LO        = 16'h0040;
  localparam logic [15:0] RAM_HI        = 16'h043F;
  localparam logic [15:0] BANK_LO       = 16'h0040;
  localparam logic [15:0] BANK_HI       = 16'h00BF;
  localparam logic [15:0] STATUS_ADDR   = 16'h003F;
  localparam logic [7:0]  DIRECT_PAGE   = 8'h00;
  localparam logic [15:0] HL_STEP       = 16'h0001;

  // Reset values
  localparam logic [3:0]  BANK_RESET    = 4'h0;
  localparam logic [15:0] PC_RESET      = 16'h0000;

  // Register offsets inside a bank: accumulator at the bank base, pairs low byte first
  localparam logic [2:0]  REG_ACC       = 3'h0;
  localparam logic [2:0]  REG_ACC_HI    = 3'h1;
  localparam logic [2:0]  REG_CNT_LO    = 3'h2;
  localparam logic [2:0]  REG_CNT_HI    = 3'h3;
  localparam logic [2:0]  REG_PTS_LO    = 3'h4;
  localparam logic [2:0]  REG_PTS_HI    = 3'h5;
  localparam logic [2:0]  REG_PTP_LO    = 3'h6;
  localparam logic [2:0]  REG_PTP_HI    = 3'h7;

  typedef enum logic [1:0] {
    CPB_S_LOAD_HI = 2'h0,
    CPB_S_LOAD_LO = 2'h1,
    CPB_S_RUN     = 2'h3,
    CPB_S_TRAP    = 2'h2
  } cpb_state_t;

  typedef enum logic [2:0] {
    CPB_K_NONE  = 3'h0,
    CPB_K_FETCH = 3'h1,
    CPB_K_JUMP  = 3'h2,
    CPB_K_READ  = 3'h3,
    CPB_K_WRITE = 3'h4
  } cpb_kind_t;

  typedef enum logic [3:0] {
    CPB_M_REG     = 4'h0,  // Register of current bank
    CPB_M_DIRECT  = 4'h1,  // Short direct, page 00
    CPB_M_ABS     = 4'h2,  // Full 16-bit address
    CPB_M_PTP     = 4'h3,  // Primary pointer
    CPB_M_PTP_D   = 4'h4,  // Primary pointer plus signed displacement
    CPB_M_PTP_C   = 4'h5,  // Primary pointer plus counter low
    CPB_M_PTP_INC = 4'h6,  // Primary pointer, then plus one
    CPB_M_PTP_DEC = 4'h7,  // Minus one, then primary pointer
    CPB_M_PTS     = 4'h8   // Secondary pointer
  } cpb_mode_t;

  typedef struct packed {
    cpb_kind_t   kind;
    cpb_mode_t   mode;
    logic        wide;
    logic        stack;
    logic [2:0]  reg_idx;
    logic [1:0]  len;
    logic [7:0]  disp;
    logic [15:0] addr;
    logic [15:0] data;
  } cpb_cmd_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [15:0] rdata;
  } cpb_rsp_t;

  function automatic logic ram_hit(input logic [15:0] a);
    return (a >= RAM_LO) && (a <= RAM_HI);
  endfunction

  function automatic logic bank_hit(input logic [15:0] a);
    return (a >= BANK_LO) && (a <= BANK_HI);
  endfunction

  function automatic logic [9:0] ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - RAM_LO;
    return d[9:0];
  endfunction

endpackage

/* rtl/cpb_bank_ram.sv */
// Purpose: 1K byte data RAM holding the register banks, with byte and pair access.
// Assumes: Indices are RAM byte addresses minus the RAM base.
// Notes:   No reset on the array; contents are undefined after power-up.
`timescale 1ns/100ps
`default_nettype none
module cpb_bank_ram (
  input  wire logic        mclk,
  input  wire logic [9:0]  rd_a_idx,
  output logic      [15:0] rd_a,
  input  wire logic [9:0]  rd_b_idx,
  output logic      [15:0] rd_b,
  input  wire logic        wr_en,
  input  wire logic        wr_wide,
  input  wire logic [9:0]  wr_idx,
  input  wire logic [15:0] wr_data
);

  logic [7:0] mem [0:1023];
  wire  [9:0] rd_a_nx = 10'(rd_a_idx + 10'h001);
  wire  [9:0] rd_b_nx = 10'(rd_b_idx + 10'h001);
  wire  [9:0] wr_nx   = 10'(wr_idx + 10'h001);

  // Pair reads: lower address is the low byte, so the accumulator sits at the bank base
  assign rd_a = {mem[rd_a_nx], mem[rd_a_idx]};
  assign rd_b = {mem[rd_b_nx], mem[rd_b_idx]};

  // Narrow writes use the low data byte
  always_ff @(posedge mclk) begin
    if (wr_en && wr_wide) begin
      mem[wr_idx] <= wr_data[7:0];
      mem[wr_nx]  <= wr_data[15:8];
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data[7:0];
    end
  end

endmodule
`default_nettype wire

/* rtl/cpb_core.sv */
// Purpose: Program counter, reset vector load, address trap and register banks.
// Assumes: ROM answers rom_data for rom_addr in the cycle after rom_addr changes.
// Notes:   Commands come from core logic on mclk; one command at a time.
`timescale 1ns/100ps
`default_nettype none
module cpb_core (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire cpb_pkg::cpb_cmd_t cmd,
  output logic                   cmd_ready,
  output cpb_pkg::cpb_rsp_t      rsp,
  input  wire logic [7:0]        rom_data,
  output logic      [15:0]       rom_addr,
  input  wire logic [3:0]        flags,
  output logic      [15:0]       pc,
  output logic      [3:0]        bank_select,
  output logic                   bus_error,
  output logic                   reset_out_n
);

  cpb_pkg::cpb_state_t state;
  cpb_pkg::cpb_cmd_t   op_cmd;
  logic [15:0]         instr_addr;
  logic [7:0]          vec_hi;
  logic [6:0]          trap_cnt;
  logic                op_busy;
  logic [15:0]         op_ea;
  logic [15:0]         rd_a;
  logic [15:0]         rd_b;

  // Command decode; new commands only in run state when idle
  wire run      = (state == cpb_pkg::CPB_S_RUN);
  wire take     = run && cmd_ready && (cmd.kind != cpb_pkg::CPB_K_NONE);
  wire is_fetch = take && (cmd.kind == cpb_pkg::CPB_K_FETCH);
  wire is_jump  = take && (cmd.kind == cpb_pkg::CPB_K_JUMP);
  wire is_mem   = take && (cmd.kind == cpb_pkg::CPB_K_READ || cmd.kind == cpb_pkg::CPB_K_WRITE);
  wire trap_hit = is_fetch && cpb_pkg::ram_hit(instr_addr);
  wire trap_end = (state == cpb_pkg::CPB_S_TRAP) && (trap_cnt == cpb_pkg::TRAP_LAST);
  wire [15:0] step_addr = instr_addr + {14'h0000, cmd.len};

  // Bank base index: {bank, reg} is 8n + r from the RAM base
  wire [9:0] bank_base = {3'h0, bank_select, 3'h0};
  wire [2:0] ptr_off   = (cmd.mode == cpb_pkg::CPB_M_PTS) ? cpb_pkg::REG_PTS_LO
                                                          : cpb_pkg::REG_PTP_LO;
  wire [9:0] ptr_idx   = bank_base | {7'h00, ptr_off};
  wire [9:0] cnt_idx   = bank_base | {7'h00, cpb_pkg::REG_CNT_LO};
  wire [2:0] reg_sel   = cmd.wide ? {cmd.reg_idx[2:1], 1'b0} : cmd.reg_idx;

  // Phase A: pointer and counter pair read from the current bank
  wire [15:0] ptr_val  = rd_a;
  wire [15:0] cnt_lo   = {8'h00, rd_b[7:0]};
  wire [15:0] disp_ext = {{8{cmd.disp[7]}}, cmd.disp};
  wire [15:0] ptr_dec  = ptr_val - cpb_pkg::HL_STEP;
  wire [15:0] ptr_inc  = ptr_val + cpb_pkg::HL_STEP;

  // Effective address selection per mode
  logic [15:0] ea;
  always_comb begin
    case (cmd.mode)
      cpb_pkg::CPB_M_REG:     ea = cpb_pkg::RAM_LO + {6'h00, bank_base | {7'h00, reg_sel}};
      cpb_pkg::CPB_M_DIRECT:  ea = {cpb_pkg::DIRECT_PAGE, cmd.addr[7:0]};
      cpb_pkg::CPB_M_ABS:     ea = cmd.addr;
      cpb_pkg::CPB_M_PTP:     ea = ptr_val;
      cpb_pkg::CPB_M_PTP_D:   ea = ptr_val + disp_ext;
      cpb_pkg::CPB_M_PTP_C:   ea = ptr_val + cnt_lo;
      cpb_pkg::CPB_M_PTP_INC: ea = ptr_val;
      cpb_pkg::CPB_M_PTP_DEC: ea = ptr_dec;
      cpb_pkg::CPB_M_PTS:     ea = ptr_val;
      default:                ea = ptr_val;
    endcase
  end

  // Pointer write-back in phase A for the auto modes
  wire ptr_upd = is_mem && (cmd.mode == cpb_pkg::CPB_M_PTP_INC ||
                            cmd.mode == cpb_pkg::CPB_M_PTP_DEC);
  wire [15:0] ptr_new = (cmd.mode == cpb_pkg::CPB_M_PTP_INC) ? ptr_inc : ptr_dec;

  // Phase B decode of the latched address
  wire [15:0] op_top    = op_ea + {15'h0000, op_cmd.wide};
  wire        status_hit = (op_ea == cpb_pkg::STATUS_ADDR) && !op_cmd.wide;
  wire        ram_ok    = cpb_pkg::ram_hit(op_ea) && cpb_pkg::ram_hit(op_top);
  // Stack traffic must stay clear of the bank area
  wire        stack_bad = op_cmd.stack &&
                          (cpb_pkg::bank_hit(op_ea) || cpb_pkg::bank_hit(op_top));
  wire        mem_ok    = ram_ok && !stack_bad;
  wire        op_wr     = (op_cmd.kind == cpb_pkg::CPB_K_WRITE);
  wire [15:0] ram_rd    = op_cmd.wide ? rd_a : {8'h00, rd_a[7:0]};
  wire [15:0] op_rdata  = status_hit ? {8'h00, flags, bank_select} :
                          mem_ok     ? ram_rd : 16'h0000;

  // RAM port steering: phase B uses the latched address
  wire [9:0]  a_idx   = op_busy ? cpb_pkg::ram_idx(op_ea) : ptr_idx;
  wire        w_en    = ptr_upd || (op_busy && op_wr && mem_ok);
  wire        w_wide  = op_busy ? op_cmd.wide : 1'b1;
  wire [9:0]  w_idx   = op_busy ? cpb_pkg::ram_idx(op_ea) : ptr_idx;
  wire [15:0] w_data  = op_busy ? op_cmd.data : ptr_new;

  cpb_bank_ram u_ram (
    .mclk     (mclk),
    .rd_a_idx (a_idx),
    .rd_a     (rd_a),
    .rd_b_idx (cnt_idx),
    .rd_b     (rd_b),
    .wr_en    (w_en),
    .wr_wide  (w_wide),
    .wr_idx   (w_idx),
    .wr_data  (w_data)
  );

  // Vector load, fetch stepping, jumps and address trap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= cpb_pkg::CPB_S_LOAD_HI;
      rom_addr    <= cpb_pkg::VEC_HI_ADDR;
      vec_hi      <= 8'h00;
      instr_addr  <= cpb_pkg::PC_RESET;
      pc          <= cpb_pkg::PC_RESET;
      trap_cnt    <= 7'h00;
      bus_error   <= 1'b0;
      reset_out_n <= 1'b1;
    end else begin
      bus_error <= trap_hit;
      case (state)
        cpb_pkg::CPB_S_LOAD_HI: begin
          vec_hi   <= rom_data;
          rom_addr <= cpb_pkg::VEC_LO_ADDR;
          state    <= cpb_pkg::CPB_S_LOAD_LO;
        end
        cpb_pkg::CPB_S_LOAD_LO: begin
          instr_addr <= {vec_hi, rom_data};
          pc         <= {vec_hi, rom_data} + cpb_pkg::PC_AHEAD;
          rom_addr   <= {vec_hi, rom_data};
          state      <= cpb_pkg::CPB_S_RUN;
        end
        cpb_pkg::CPB_S_RUN: begin
          if (trap_hit) begin
            state       <= cpb_pkg::CPB_S_TRAP;
            reset_out_n <= 1'b0;
            trap_cnt    <= 7'h00;
          end else if (is_fetch) begin
            instr_addr <= step_addr;
            pc         <= step_addr + cpb_pkg::PC_AHEAD;
            rom_addr   <= step_addr;
          end else if (is_jump) begin
            instr_addr <= cmd.addr;
            pc         <= cmd.addr + cpb_pkg::PC_AHEAD;
            rom_addr   <= cmd.addr;
          end
        end
        cpb_pkg::CPB_S_TRAP: begin
          trap_cnt <= 7'(trap_cnt + 7'h01);
          if (trap_end) begin
            state       <= cpb_pkg::CPB_S_LOAD_HI;               // Restart as after reset
            rom_addr    <= cpb_pkg::VEC_HI_ADDR;
            reset_out_n <= 1'b1;
          end
        end
        default: state <= cpb_pkg::CPB_S_LOAD_HI;
      endcase
    end
  end

  // Two-phase memory access: latch address, then access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_busy <= 1'b0;
      op_ea   <= 16'h0000;
      op_cmd  <= '0;
    end else begin
      op_busy <= is_mem;
      if (is_mem) begin
        op_ea  <= ea;
        op_cmd <= cmd;
      end
    end
  end

  // Ready drops for the access and during vector load or trap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (state == cpb_pkg::CPB_S_LOAD_LO) ||
                   (run && !trap_hit && !is_mem);
    end
  end

  // Answer is a one-cycle pulse after phase B
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp.done  <= op_busy;
      rsp.err   <= op_busy && !(status_hit || mem_ok);
      rsp.rdata <= (op_busy && !op_wr) ? op_rdata : 16'h0000;
    end
  end

  // Bank select: cleared on any reset, writable through the status word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select <= cpb_pkg::BANK_RESET;
    end else if (!run) begin
      bank_select <= cpb_pkg::BANK_RESET;
    end else if (op_busy && op_wr && status_hit) begin
      bank_select <= op_cmd.data[3:0];                           // Flags stay read-only
    end
  end

endmodule
`default_nettype wire

/* verif/cpb_rom_model.sv */
// Purpose: Program ROM stand-in answering bytes to the core.
// Assumes: Reset vector C03E; other bytes are a scrambled address byte.
// Notes:   Combinational, like the array read port.
`timescale 1ns/100ps
`default_nettype none
module cpb_rom_model (
  input  wire logic [15:0] rom_addr,
  output logic      [7:0]  rom_data
);
  // Vector high byte at FFFF, low byte at FFFE
  always_comb begin
    case (rom_addr)
      16'hFFFF: rom_data = 8'hC0;
      16'hFFFE: rom_data = 8'h3E;
      default:  rom_data = rom_addr[7:0] ^ 8'h5A;
    endcase
  end
endmodule
`default_nettype wire

/* verif/cpb_core_properties.sv */
// Purpose: Timing relations at the core ports.
// Assumes: rom_addr holds the instruction address while commands run.
// Notes:   Trap length is allowed one cycle of slack either way.
`timescale 1ns/100ps
`default_nettype none
module cpb_core_properties (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire cpb_pkg::cpb_cmd_t cmd,
  input wire logic              cmd_ready,
  input wire cpb_pkg::cpb_rsp_t rsp,
  input wire logic [15:0]       rom_addr,
  input wire logic [15:0]       pc,
  input wire logic [3:0]        bank_select,
  input wire logic              bus_error,
  input wire logic              reset_out_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] low_cnt;
  // Trap pulse length; saturates so a stuck pin cannot wrap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 8'h00;
    else if (reset_out_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  // Request decode
  wire take   = cmd_ready && (cmd.kind != cpb_pkg::CPB_K_NONE);
  wire is_wr  = cmd.kind == cpb_pkg::CPB_K_WRITE;
  wire mem_op = take && (is_wr || cmd.kind == cpb_pkg::CPB_K_READ);
  wire fetch  = take && cmd.kind == cpb_pkg::CPB_K_FETCH;
  wire in_ram = rom_addr >= 16'h0040 && rom_addr <= 16'h043F;
  wire st_wr  = take && is_wr && cmd.mode == cpb_pkg::CPB_M_ABS &&
                cmd.addr == 16'h003F && !cmd.wide;
  sequence s_busy; !cmd_ready; endsequence
  sequence s_answer; rsp.done && cmd_ready; endsequence
  a_mem_walk: assert property (mem_op |=> s_busy ##1 s_answer)
    else $error("memory access walk broken");
  a_pc_ahead: assert property (cmd_ready |-> pc == rom_addr + 16'h0002)
    else $error("pc not two ahead");
  a_fetch_step: assert property (fetch && !in_ram |=>
    rom_addr == $past(rom_addr) + {14'h0000, $past(cmd.len)}) else $error("fetch step wrong");
  a_jump_load: assert property (take && cmd.kind == cpb_pkg::CPB_K_JUMP |=>
    rom_addr == $past(cmd.addr)) else $error("jump target wrong");
  a_fetch_trap: assert property (fetch && in_ram |=> bus_error && !cmd_ready)
    else $error("no trap on data fetch");
  a_trap_pin: assert property (bus_error |-> !reset_out_n)
    else $error("reset pin high in trap");
  a_trap_len: assert property ($rose(reset_out_n) |->
    low_cnt >= 8'h63 && low_cnt <= 8'h65) else $error("trap pulse length wrong");
  a_trap_bank: assert property ($rose(reset_out_n) |-> bank_select == 4'h0)
    else $error("bank not cleared by trap");
  a_err_done: assert property (rsp.err |-> rsp.done)
    else $error("error without done");
  a_status_wr: assert property (st_wr |=> ##1 bank_select == $past(cmd.data[3:0], 2))
    else $error("bank select not written");
endmodule
bind cpb_core cpb_core_properties i_props (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
  .cmd_ready(cmd_ready), .rsp(rsp), .rom_addr(rom_addr), .pc(pc),
  .bank_select(bank_select), .bus_error(bus_error), .reset_out_n(reset_out_n));
`default_nettype wire

/* verif/cpb_core_test.sv */
// Purpose: Self-checking bench for the program counter and register banks.
// Assumes: ROM model vector C03E; flags tied to A.
// Notes:   Bank 5 is used so bank-relative addressing is exercised.
`timescale 1ns/100ps
`default_nettype none
module cpb_core_test;
  logic              mclk, rst_n, cmd_ready, bus_error, reset_out_n;
  cpb_pkg::cpb_cmd_t cmd;
  cpb_pkg::cpb_rsp_t rsp, r;
  logic [7:0]        rom_data;
  logic [15:0]       rom_addr, pc;
  logic [3:0]        flags, bank_select;
  int                fail_count, checks;
  logic [7:0]        disp;
  localparam logic [15:0] VEC = 16'hC03E;
  cpb_core i_dut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp),
    .rom_data(rom_data), .rom_addr(rom_addr), .flags(flags), .pc(pc),
    .bank_select(bank_select), .bus_error(bus_error), .reset_out_n(reset_out_n));
  cpb_rom_model i_rom (.rom_addr(rom_addr), .rom_data(rom_data));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait on an edge for the core to accept
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk({15'h0000, cmd_ready}, 16'h0001);
  endtask
  // Hold one command until the edge that takes it, then go idle
  task automatic issue(input cpb_pkg::cpb_kind_t k, input cpb_pkg::cpb_mode_t m,
      input logic w, input logic s, input logic [2:0] i, input logic [1:0] len,
      input logic [15:0] a, input logic [15:0] d);
    wait_ready();
    cmd <= '{k, m, w, s, i, len, disp, a, d};
    @(posedge mclk);
    cmd.kind <= cpb_pkg::CPB_K_NONE;
  endtask
  task automatic mem(input cpb_pkg::cpb_kind_t k, input cpb_pkg::cpb_mode_t m,
      input logic w, input logic s, input logic [2:0] i, input logic [15:0] a,
      input logic [15:0] d);
    int n;
    issue(k, m, w, s, i, 2'h0, a, d);
    n = 0;
    r = '0;
    while (n < 8 && r.done !== 1'b1) begin
      @(posedge mclk);
      r = rsp;
      n++;
    end
    chk({15'h0000, r.done}, 16'h0001);
  endtask
  task automatic t_vector;
    wait_ready();
    chk(rom_addr, VEC);
    chk(pc, VEC + 16'h0002);
    chk({12'h000, bank_select}, 16'h0000);
  endtask
  // Longest fetch then a far jump; pc stays two ahead
  task automatic t_flow;
    issue(cpb_pkg::CPB_K_FETCH, cpb_pkg::CPB_M_REG, 1'b0, 1'b0, 3'h0, 2'h3, 16'h0000, 16'h0000);
    #1;
    chk(rom_addr, VEC + 16'h0003);
    chk(pc, VEC + 16'h0005);
    @(posedge mclk);
    issue(cpb_pkg::CPB_K_JUMP, cpb_pkg::CPB_M_REG, 1'b0, 1'b0, 3'h0, 2'h0, 16'hFFF0, 16'h0000);
    #1;
    chk(pc, 16'hFFF2);
    @(posedge mclk);
  endtask
  task automatic t_banks;
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h003F, 16'h00F5);
    chk({12'h000, bank_select}, 16'h0005);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h003F, 16'h0000);
    chk(r.rdata, 16'h00A5);
    // Accumulator of bank 5 is the first byte of the bank
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_REG, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h00C3);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h0068, 16'h0000);
    chk(r.rdata, 16'h00C3);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_REG, 1'b1, 1'b0, 3'h0, 16'h0000, 16'h1234);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_DIRECT, 1'b0, 1'b0, 3'h0, 16'h0068, 16'h0000);
    chk(r.rdata, 16'h0034);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h0069, 16'h0000);
    chk(r.rdata, 16'h0012);
    // Pointer use, then step; step then use
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_REG, 1'b1, 1'b0, 3'h6, 16'h0000, 16'h0100);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_PTP_INC, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0077);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_REG, 1'b1, 1'b0, 3'h6, 16'h0000, 16'h0000);
    chk(r.rdata, 16'h0101);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_PTP_DEC, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000);
    chk(r.rdata, 16'h0077);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_REG, 1'b1, 1'b0, 3'h4, 16'h0000, 16'h0100);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_PTS, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000);
    chk(r.rdata, 16'h0077);
    // Counter low offset, negative displacement, then plain primary pointer
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_REG, 1'b0, 1'b0, 3'h2, 16'h0000, 16'h0005);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h0105, 16'h0066);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_PTP_C, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000);
    chk(r.rdata, 16'h0066);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h00FB, 16'h0044);
    disp = 8'hFB;
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_PTP_D, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000);
    chk(r.rdata, 16'h0044);
    disp = 8'h00;
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_PTP, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000);
    chk(r.rdata, 16'h0077);
  endtask
  // RAM edges and stack placement
  task automatic t_bounds;
    // Last RAM byte is written before it is read, never read while undefined
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h043F, 16'h005A);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h043F, 16'h0000);
    chk({15'h0000, r.err}, 16'h0000);
    chk(r.rdata, 16'h005A);
    mem(cpb_pkg::CPB_K_READ, cpb_pkg::CPB_M_ABS, 1'b0, 1'b0, 3'h0, 16'h0440, 16'h0000);
    chk({15'h0000, r.err}, 16'h0001);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_ABS, 1'b0, 1'b1, 3'h0, 16'h00BF, 16'h0011);
    chk({15'h0000, r.err}, 16'h0001);
    mem(cpb_pkg::CPB_K_WRITE, cpb_pkg::CPB_M_ABS, 1'b0, 1'b1, 3'h0, 16'h00C0, 16'h0011);
    chk({15'h0000, r.err}, 16'h0000);
  endtask
  // Fetch from data RAM; bank select is non-zero beforehand
  task automatic t_trap;
    issue(cpb_pkg::CPB_K_JUMP, cpb_pkg::CPB_M_REG, 1'b0, 1'b0, 3'h0, 2'h0, 16'h0100, 16'h0000);
    @(posedge mclk);
    issue(cpb_pkg::CPB_K_FETCH, cpb_pkg::CPB_M_REG, 1'b0, 1'b0, 3'h0, 2'h0, 16'h0000, 16'h0000);
    #1;
    chk({15'h0000, bus_error}, 16'h0001);
    chk({15'h0000, reset_out_n}, 16'h0000);
    @(posedge mclk);
    wait_ready();
    chk(pc, VEC + 16'h0002);
    chk({12'h000, bank_select}, 16'h0000);
  endtask
  initial begin
    rst_n = 1'b0;
    cmd = '0;
    flags = 4'hA;
    disp = 8'h00;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_vector();
    t_flow();
    t_banks();
    t_bounds();
    t_trap();
    end_of_test();
  end
  // Tests need well under 1000 cycles; 20000 means a hang
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
